// file: src/tlb_mgmt_defs.svh
// Constants for the translation-buffer management register set
// ----------------------------------------------------------------
// How it works
// - Registers read/written by move ops, selected by number
// - Move ops need kernel mode or usable bit 28; translation ops are not gated
// - Entry-select is 32 bits, six-bit index
// - Probe miss sets entry-select top bit
// - Read and indexed write use entry-select index
// - Reserved fields written zero, read zero
// - Replacement pointer is read-only, six bits
// - Pointer decrements on each graduating cycle above locked count
// - Pointer stays between locked count and top
// - Random write uses current pointer value
// - Pointer loads top on reset, locked write
// - Even and odd page-frame registers, same layout
// - Frame number gives address bits 33:6
// - Bits 63:62 hold uncached attribute, copied
// - Uncached attribute driven on bus 59:58
// - 64 bits wide; 32-bit user sees low half
// - Sign-extended load makes bits 33:31 uniform
// - Frame mask masks frame; attribute needs kernel or 64-bit mode
// - Global flag from both bit 0s
// - Hit on invalid entry raises invalid exception
// - Locked count clears to zero on reset
// ----------------------------------------------------------------
`ifndef TLB_MGMT_DEFS_SVH
`define TLB_MGMT_DEFS_SVH
`define REG_ENTRY_SELECT 5'h00
`define REG_REPLACE_PTR 5'h01
`define REG_EVEN_FRAME 5'h02
`define REG_ODD_FRAME 5'h03
`define REG_LOCKED_COUNT 5'h06
`define REG_FRAME_MASK 5'h15
`define KERNEL_OPS_BIT 28
`define PROBE_MISS_BIT 31
`define UC_HI 63
`define UC_LO 62
`define PFN_HI 33
`define PFN_LO 6
`define BUS_UC_HI 59
`define BUS_UC_LO 58
`define GLOBAL_BIT 0
`define VALID_BIT 1
`define FRAME_RW_MASK 64'hC000_0003_FFFF_FFFF
`endif

// file: src/tlb_mgmt_pkg.sv
// Types for the translation-buffer management register set
package tlb_mgmt_pkg;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_MOVE_FROM = 2'b01,
    OP_MOVE_TO = 2'b10
  } move_op_t;

  typedef enum logic [2:0] {
    TOP_NONE = 3'b000,
    TOP_PROBE = 3'b001,
    TOP_READ = 3'b010,
    TOP_WRITE_INDEXED = 3'b011,
    TOP_WRITE_RANDOM = 3'b100
  } tlb_op_t;

  // A full entry as it moves between registers and the array
  typedef struct packed {
    logic [63:0] even_frame;
    logic [63:0] odd_frame;
    logic global_flag;
  } tlb_entry_t;

  typedef struct packed {
    logic [5:0] index;
    logic probe_miss;
    logic [5:0] replace_ptr;
    logic [5:0] locked_count;
    logic [63:0] even_frame;
    logic [63:0] odd_frame;
    logic [63:0] frame_mask;
    logic [63:0] rd_data;
    logic rd_valid;
    logic unusable;
    logic [5:0] arr_index;
    logic arr_we;
    tlb_entry_t arr_wdata;
    logic [1:0] bus_uc;
    logic inval_load;
    logic inval_store;
  } state_t;
endpackage

// file: src/tlb_mgmt_regs.sv
// Translation-buffer management registers of the system control coprocessor
`timescale 1ns/100ps
`include "tlb_mgmt_defs.svh"
module tlb_mgmt_regs #(
  parameter int ENTRIES = 64
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Privilege state
  input wire logic kernel_mode_i,
  input wire logic [31:0] status_i,
  input wire logic mode64_i,
  // Move to and from the coprocessor
  input wire tlb_mgmt_pkg::move_op_t move_op_i,
  input wire logic [4:0] reg_num_i,
  input wire logic [63:0] wr_data_i,
  output logic [63:0] rd_data_o,
  output logic rd_valid_o,
  output logic unusable_o,
  // Translation operations
  input wire tlb_mgmt_pkg::tlb_op_t tlb_op_i,
  input wire logic probe_hit_i,
  input wire logic [5:0] probe_index_i,
  input wire tlb_mgmt_pkg::tlb_entry_t arr_rdata_i,
  output logic [5:0] arr_index_o,
  output logic arr_we_o,
  output tlb_mgmt_pkg::tlb_entry_t arr_wdata_o,
  // Pipeline events
  input wire logic graduate_i,
  // Lookup result and bus address cycle
  input wire logic lookup_hit_i,
  input wire logic lookup_store_i,
  input wire logic lookup_valid_i,
  input wire logic [1:0] lookup_uc_i,
  input wire logic addr_cycle_i,
  output logic [1:0] bus_uc_o,
  output logic inval_load_o,
  output logic inval_store_o
);
  import tlb_mgmt_pkg::*;

  localparam logic [5:0] TOP = 6'(ENTRIES - 1);

  state_t st_reg;
  state_t st_next;
  logic allowed;
  logic wide;
  logic [63:0] wval;
  logic [63:0] masked_even;
  logic [63:0] masked_odd;

  // Pointer step: reload top instead of entering the locked region
  function automatic logic [5:0] ptr_step(input logic [5:0] p, input logic [5:0] lo);
    ptr_step = (p <= lo || p == 6'h00) ? TOP : p - 6'h01;
  endfunction

  // Apply frame mask to the frame number only
  function automatic logic [63:0] mask_frame(input logic [63:0] f, input logic [63:0] m);
    mask_frame = f & ~(m & 64'h0000_0003_FFFF_FFC0);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Privilege check gates every move op; translation ops are not gated
  assign allowed = kernel_mode_i || status_i[`KERNEL_OPS_BIT];

  // Full 64-bit access in kernel mode or with 64-bit ops enabled
  assign wide = mode64_i || kernel_mode_i;

  // In 32-bit user mode only the low word is written, sign-extended
  assign wval = (mode64_i || kernel_mode_i) ? wr_data_i
    : {{32{wr_data_i[31]}}, wr_data_i[31:0]};

  assign masked_even = mask_frame(st_reg.even_frame, st_reg.frame_mask);
  assign masked_odd = mask_frame(st_reg.odd_frame, st_reg.frame_mask);

  always_comb
  begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.unusable = 1'b0;
    st_next.arr_we = 1'b0;
    st_next.inval_load = 1'b0;
    st_next.inval_store = 1'b0;
    st_next.bus_uc = 2'b00;
    // Pointer steps only on graduation; a locked-count write reloads it to top
    if (graduate_i)
    begin
      st_next.replace_ptr = ptr_step(st_reg.replace_ptr, st_reg.locked_count);
    end
    // Move operations
    if (move_op_i != OP_NONE && !allowed)
    begin
      st_next.unusable = 1'b1;
    end
    else if (move_op_i == OP_MOVE_FROM)
    begin
      st_next.rd_valid = 1'b1;
      unique case (reg_num_i)
        `REG_ENTRY_SELECT: st_next.rd_data = {32'h0, st_reg.probe_miss, 25'h0, st_reg.index};
        `REG_REPLACE_PTR: st_next.rd_data = {58'h0, st_reg.replace_ptr};
        `REG_EVEN_FRAME: st_next.rd_data = (mode64_i || kernel_mode_i) ? st_reg.even_frame
          : {{32{st_reg.even_frame[31]}}, st_reg.even_frame[31:0]};
        `REG_ODD_FRAME: st_next.rd_data = (mode64_i || kernel_mode_i) ? st_reg.odd_frame
          : {{32{st_reg.odd_frame[31]}}, st_reg.odd_frame[31:0]};
        `REG_LOCKED_COUNT: st_next.rd_data = {58'h0, st_reg.locked_count};
        `REG_FRAME_MASK: st_next.rd_data = st_reg.frame_mask;
        default: st_next.rd_data = 64'h0;
      endcase
    end
    else if (move_op_i == OP_MOVE_TO)
    begin
      unique case (reg_num_i)
        `REG_ENTRY_SELECT: st_next.index = wval[5:0];
        // Sign extension must not reach the attribute bits in narrow mode
        `REG_EVEN_FRAME: st_next.even_frame = {(wide ? wval[63:62] : st_reg.even_frame[63:62]),
          wval[61:0]} & `FRAME_RW_MASK;
        `REG_ODD_FRAME: st_next.odd_frame = {(wide ? wval[63:62] : st_reg.odd_frame[63:62]),
          wval[61:0]} & `FRAME_RW_MASK;
        `REG_LOCKED_COUNT:
        begin
          st_next.locked_count = wval[5:0];
          st_next.replace_ptr = TOP;
        end
        `REG_FRAME_MASK: st_next.frame_mask = wval;
        default: st_next.index = st_reg.index; // Read-only pointer ignores writes
      endcase
    end
    // Translation operations
    unique case (tlb_op_i)
      TOP_PROBE:
      begin
        st_next.probe_miss = !probe_hit_i;
        if (probe_hit_i)
        begin
          st_next.index = probe_index_i;
        end
      end
      TOP_READ:
      begin
        st_next.arr_index = st_reg.index;
        // Mask keeps reserved bits zero even for never-written entries
        st_next.even_frame = arr_rdata_i.even_frame & `FRAME_RW_MASK;
        st_next.odd_frame = arr_rdata_i.odd_frame & `FRAME_RW_MASK;
      end
      TOP_WRITE_INDEXED, TOP_WRITE_RANDOM:
      begin
        st_next.arr_index = (tlb_op_i == TOP_WRITE_RANDOM) ? st_reg.replace_ptr
          : st_reg.index;
        st_next.arr_we = 1'b1;
        st_next.arr_wdata.even_frame = masked_even;
        st_next.arr_wdata.odd_frame = masked_odd;
        st_next.arr_wdata.global_flag = st_reg.even_frame[`GLOBAL_BIT]
          & st_reg.odd_frame[`GLOBAL_BIT];
      end
      // Idle: array follows the select so a read op finds its entry ready
      default: st_next.arr_index = st_next.index;
    endcase
    // Lookup results: invalid page and bus attribute
    if (lookup_hit_i && !lookup_valid_i)
    begin
      st_next.inval_load = !lookup_store_i;
      st_next.inval_store = lookup_store_i;
    end
    if (addr_cycle_i)
    begin
      st_next.bus_uc = lookup_uc_i;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_reg <= '0;
      st_reg.replace_ptr <= TOP;
      st_reg.locked_count <= 6'h00;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register
  assign rd_data_o = st_reg.rd_data;
  assign rd_valid_o = st_reg.rd_valid;
  assign unusable_o = st_reg.unusable;
  assign arr_index_o = st_reg.arr_index;
  assign arr_we_o = st_reg.arr_we;
  assign arr_wdata_o = st_reg.arr_wdata;
  assign bus_uc_o = st_reg.bus_uc;
  assign inval_load_o = st_reg.inval_load;
  assign inval_store_o = st_reg.inval_store;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ptr_bounds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    st_reg.replace_ptr <= TOP) else $error("pointer above top");
  a_ptr_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !graduate_i && !(move_op_i == OP_MOVE_TO && reg_num_i == `REG_LOCKED_COUNT && allowed)
    |=> $stable(st_reg.replace_ptr)) else $error("pointer moved without graduation");
  a_locked_reload: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_TO && reg_num_i == `REG_LOCKED_COUNT && allowed
    |=> st_reg.replace_ptr == TOP) else $error("pointer not reloaded");
  a_unusable_op: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i != OP_NONE && !allowed |=> unusable_o && !rd_valid_o)
    else $error("unprivileged op not refused");
  a_probe_miss: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    tlb_op_i == TOP_PROBE && !probe_hit_i |=> st_reg.probe_miss)
    else $error("probe miss not flagged");
  a_random_index: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    tlb_op_i == TOP_WRITE_RANDOM |=> arr_we_o && arr_index_o == $past(st_reg.replace_ptr))
    else $error("random write wrong entry");
  a_global_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    arr_we_o |-> arr_wdata_o.global_flag == (arr_wdata_o.even_frame[0] & arr_wdata_o.odd_frame[0]))
    else $error("global flag wrong");
  a_select_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_valid_o && $past(reg_num_i) == `REG_ENTRY_SELECT |-> rd_data_o[30:6] == 25'h0)
    else $error("reserved bits nonzero");
  a_invalid_exc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    lookup_hit_i && !lookup_valid_i |=> (inval_load_o ^ inval_store_o))
    else $error("invalid exception missing");

  // ----------------------------------------------------------------
  // Register read-back checks
  // ----------------------------------------------------------------
  // Pointer read returns the value held when the read was taken
  a_rd_ptr_value: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_FROM && allowed && reg_num_i == `REG_REPLACE_PTR
    |=> rd_data_o == {58'h0, $past(st_reg.replace_ptr)})
    else $error("pointer read wrong");

  // Select read carries the index and the miss flag in place
  a_rd_index_value: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_FROM && allowed && reg_num_i == `REG_ENTRY_SELECT
    |=> rd_data_o[5:0] == $past(st_reg.index) && rd_data_o[31] == $past(st_reg.probe_miss))
    else $error("select read wrong");

  // Entry-select and pointer registers read zero in their upper word
  a_rd_upper_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_FROM && allowed && reg_num_i <= `REG_REPLACE_PTR
    |=> rd_data_o[63:32] == 32'h0)
    else $error("upper word nonzero");

  // Unmapped register numbers read as zero
  a_rd_unmapped: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_FROM && allowed && reg_num_i == 5'h09
    |=> rd_data_o == 64'h0)
    else $error("unmapped read nonzero");

  // Narrow mode shows only the sign-extended low word
  a_narrow_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_FROM && allowed && !wide && reg_num_i == `REG_EVEN_FRAME
    |=> rd_data_o[63:32] == {32{rd_data_o[31]}})
    else $error("narrow read not extended");

  // ----------------------------------------------------------------
  // Replacement pointer checks
  // ----------------------------------------------------------------
  // Software writes to the pointer have no effect
  a_ptr_readonly: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_TO && allowed && reg_num_i == `REG_REPLACE_PTR && !graduate_i
    |=> $stable(st_reg.replace_ptr))
    else $error("pointer written by software");

  // A graduation above the floor steps down by exactly one
  a_ptr_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    graduate_i && st_reg.replace_ptr > st_reg.locked_count
    && !(move_op_i == OP_MOVE_TO && allowed && reg_num_i == `REG_LOCKED_COUNT)
    |=> st_reg.replace_ptr == $past(st_reg.replace_ptr) - 6'h01)
    else $error("pointer step wrong");

  // A graduation at the floor wraps to the top
  a_ptr_wrap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    graduate_i && (st_reg.replace_ptr <= st_reg.locked_count || st_reg.replace_ptr == 6'h00)
    && !(move_op_i == OP_MOVE_TO && allowed && reg_num_i == `REG_LOCKED_COUNT)
    |=> st_reg.replace_ptr == TOP)
    else $error("pointer did not wrap");

  // Pointer never names a locked entry unless it sits at the top
  a_ptr_floor: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    st_reg.replace_ptr >= st_reg.locked_count || st_reg.replace_ptr == TOP)
    else $error("pointer in locked region");

  // Reset leaves the pointer at its top
  a_reset_ptr: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> st_reg.replace_ptr == TOP)
    else $error("pointer not at top after reset");

  // Reset clears the locked count
  a_reset_locked: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> st_reg.locked_count == 6'h00)
    else $error("locked count not cleared");

  // A refused op leaves the register contents alone
  a_refused_state: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i != OP_NONE && !allowed && tlb_op_i == TOP_NONE && !graduate_i
    |=> $stable(st_reg.index) && $stable(st_reg.locked_count) && $stable(st_reg.replace_ptr))
    else $error("refused op changed state");

  // ----------------------------------------------------------------
  // Array write checks
  // ----------------------------------------------------------------
  // Indexed write goes to the selected entry
  a_write_index: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    tlb_op_i == TOP_WRITE_INDEXED
    |=> arr_we_o && arr_index_o == $past(st_reg.index))
    else $error("indexed write wrong entry");

  // Frame number reaches the array through the mask
  a_frame_data: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    tlb_op_i == TOP_WRITE_INDEXED || tlb_op_i == TOP_WRITE_RANDOM
    |=> arr_wdata_o.even_frame[33:6] == ($past(st_reg.even_frame[33:6]) & ~$past(st_reg.frame_mask[33:6])))
    else $error("frame number wrong");

  // Attribute bits are copied unmasked into both halves
  a_uc_copy: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    tlb_op_i == TOP_WRITE_INDEXED || tlb_op_i == TOP_WRITE_RANDOM
    |=> arr_wdata_o.even_frame[63:62] == $past(st_reg.even_frame[63:62])
    && arr_wdata_o.odd_frame[63:62] == $past(st_reg.odd_frame[63:62]))
    else $error("attribute not copied");

  // Narrow writes give uniform bits 33:31
  a_sign_uniform: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_TO && allowed && !wide && reg_num_i == `REG_EVEN_FRAME
    && tlb_op_i != TOP_READ
    |=> st_reg.even_frame[33:31] == 3'b000 || st_reg.even_frame[33:31] == 3'b111)
    else $error("bits 33:31 mixed");

  // Narrow writes cannot set the attribute bits
  a_uc_locked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    move_op_i == OP_MOVE_TO && allowed && !wide && reg_num_i == `REG_EVEN_FRAME
    && tlb_op_i == TOP_NONE
    |=> $stable(st_reg.even_frame[63:62]))
    else $error("attribute set in narrow mode");

  // ----------------------------------------------------------------
  // System bus attribute checks
  // ----------------------------------------------------------------
  // Attribute follows the address cycle by one clock
  a_bus_attr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    addr_cycle_i |=> bus_uc_o == $past(lookup_uc_i))
    else $error("bus attribute wrong");

  // Outside address cycles the attribute lines rest at zero
  a_bus_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !addr_cycle_i |=> bus_uc_o == 2'b00)
    else $error("bus attribute not idle");
endmodule // tlb_mgmt_regs

// file: dv/tlb_array_model.sv
// Behavioural translation-buffer array that faces the management registers
`timescale 1ns/100ps
module tlb_array_model
  import tlb_mgmt_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Array port driven by the registers
  input wire logic [5:0] index_i,
  input wire logic we_i,
  input wire tlb_mgmt_pkg::tlb_entry_t wdata_i,
  output tlb_mgmt_pkg::tlb_entry_t rdata_o
);
  tlb_entry_t mem [64];

  // Store on the write pulse; unwritten entries stay unknown on purpose
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
    begin
      mem[index_i] <= wdata_i;
    end
  end

  // Read data is combinational so it is ready in the cycle of a read op
  assign rdata_o = mem[index_i];
endmodule // tlb_array_model

// file: dv/tb_tlb_management_registers.sv
// Self-checking testbench for the translation-buffer management registers
`timescale 1ns/100ps
module tb_tlb_management_registers;
  import tlb_mgmt_pkg::*;
  // Small array so pointer wrap is reached quickly
  localparam int N = 16;
  logic sys_clk_i, sys_rst_i, kernel_mode_i, mode64_i, rd_valid_o, unusable_o;
  logic [31:0] status_i;
  move_op_t move_op_i;
  logic [4:0] reg_num_i;
  logic [63:0] wr_data_i, rd_data_o;
  tlb_op_t tlb_op_i;
  logic probe_hit_i, arr_we_o, graduate_i, lookup_hit_i, lookup_store_i;
  logic lookup_valid_i, addr_cycle_i, inval_load_o, inval_store_o;
  logic [5:0] probe_index_i, arr_index_o;
  logic [1:0] lookup_uc_i, bus_uc_o;
  tlb_entry_t arr_rdata_i, arr_wdata_o;
  int mismatches = 0;
  int checks = 0;

  tlb_mgmt_regs #(.ENTRIES(N)) tlb_mgmt_regs_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .kernel_mode_i(kernel_mode_i), .status_i(status_i), .mode64_i(mode64_i),
    .move_op_i(move_op_i), .reg_num_i(reg_num_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .unusable_o(unusable_o),
    .tlb_op_i(tlb_op_i), .probe_hit_i(probe_hit_i), .probe_index_i(probe_index_i),
    .arr_rdata_i(arr_rdata_i), .arr_index_o(arr_index_o), .arr_we_o(arr_we_o),
    .arr_wdata_o(arr_wdata_o), .graduate_i(graduate_i), .lookup_hit_i(lookup_hit_i),
    .lookup_store_i(lookup_store_i), .lookup_valid_i(lookup_valid_i),
    .lookup_uc_i(lookup_uc_i), .addr_cycle_i(addr_cycle_i), .bus_uc_o(bus_uc_o),
    .inval_load_o(inval_load_o), .inval_store_o(inval_store_o));

  tlb_array_model tlb_array_model_i (.sys_clk_i(sys_clk_i), .index_i(arr_index_o),
    .we_i(arr_we_o), .wdata_i(arr_wdata_o), .rdata_o(arr_rdata_i));

  // ----------------------------------------------------------------
  // Clock, compare and closing tasks
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One move op; answer is registered, so look just after the edge that takes it
  task automatic mv(input move_op_t op, input logic [4:0] n, input logic [63:0] d);
    @(posedge sys_clk_i);
    move_op_i <= op;
    reg_num_i <= n;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    move_op_i <= OP_NONE;
    #1;
  endtask

  task automatic rd(input logic [4:0] n, input logic [63:0] exp);
    mv(OP_MOVE_FROM, n, 64'h0);
    chk(64'(rd_valid_o), 64'h1);
    chk(rd_data_o, exp);
  endtask

  task automatic top(input tlb_op_t op);
    @(posedge sys_clk_i);
    tlb_op_i <= op;
    @(posedge sys_clk_i);
    tlb_op_i <= TOP_NONE;
    #1;
  endtask

  // Graduation held for exactly n sampling edges
  task automatic grad(input int n);
    @(posedge sys_clk_i);
    graduate_i <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    graduate_i <= 1'b0;
  endtask

  // Hard cap on run length in case the design stalls the sequence
  initial
  begin
    #200000;
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst_i = 1'b1; kernel_mode_i = 1'b1; status_i = 32'h0; mode64_i = 1'b1;
    move_op_i = OP_NONE; reg_num_i = 5'h00; wr_data_i = 64'h0; tlb_op_i = TOP_NONE;
    probe_hit_i = 1'b0; probe_index_i = 6'h00; graduate_i = 1'b0; lookup_hit_i = 1'b0;
    lookup_store_i = 1'b0; lookup_valid_i = 1'b0; lookup_uc_i = 2'h0; addr_cycle_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(5'h01, 64'(N - 1));
    rd(5'h06, 64'h0);
    rd(5'h09, 64'h0);
    mv(OP_MOVE_TO, 5'h01, 64'h0);
    rd(5'h01, 64'(N - 1));
    grad(3);
    rd(5'h01, 64'(N - 4));
    mv(OP_MOVE_TO, 5'h06, 64'hA);
    rd(5'h01, 64'(N - 1));
    grad(N - 11);
    rd(5'h01, 64'hA);
    grad(1);
    rd(5'h01, 64'(N - 1));
    top(TOP_WRITE_RANDOM);
    chk({arr_index_o, arr_we_o}, {6'(N - 1), 1'b1});
    mv(OP_MOVE_TO, 5'h00, 64'h25);
    rd(5'h00, 64'h25);
    mv(OP_MOVE_TO, 5'h15, 64'h0);
    mv(OP_MOVE_TO, 5'h02, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(5'h02, 64'hC000_0003_FFFF_FFFF);
    mv(OP_MOVE_TO, 5'h03, 64'h4000_0001_2345_6781);
    rd(5'h03, 64'h4000_0001_2345_6781);
    top(TOP_WRITE_INDEXED);
    chk({arr_index_o, arr_we_o}, {6'h25, 1'b1});
    chk(arr_wdata_o.even_frame, 64'hC000_0003_FFFF_FFFF);
    chk(arr_wdata_o.odd_frame, 64'h4000_0001_2345_6781);
    chk(64'(arr_wdata_o.global_flag), 64'h1);
    mv(OP_MOVE_TO, 5'h02, 64'h0);
    top(TOP_READ);
    rd(5'h02, 64'hC000_0003_FFFF_FFFF);
    probe_hit_i <= 1'b0;
    top(TOP_PROBE);
    rd(5'h00, 64'h8000_0025);
    probe_hit_i <= 1'b1;
    probe_index_i <= 6'h07;
    top(TOP_PROBE);
    rd(5'h00, 64'h07);
    // Mask bits 7:6 of the frame number on the next write
    mv(OP_MOVE_TO, 5'h15, 64'hC0);
    top(TOP_WRITE_INDEXED);
    chk(arr_wdata_o.even_frame, 64'hC000_0003_FFFF_FF3F);
    // Privilege: refused without kernel mode, granted by bit 28
    kernel_mode_i <= 1'b0;
    mv(OP_MOVE_FROM, 5'h00, 64'h0);
    chk({unusable_o, rd_valid_o}, 2'b10);
    status_i <= 32'h1000_0000;
    rd(5'h00, 64'h07);
    // Narrow mode: low word only, sign-extended; attribute bits untouched
    mode64_i <= 1'b0;
    mv(OP_MOVE_TO, 5'h02, 64'h8000_0041);
    rd(5'h02, 64'hFFFF_FFFF_8000_0041);
    kernel_mode_i <= 1'b1;
    rd(5'h02, 64'hC000_0003_8000_0041);
    // Address cycle carries the page's attribute; hit on invalid entry faults
    @(posedge sys_clk_i);
    addr_cycle_i <= 1'b1;
    lookup_uc_i <= 2'h2;
    lookup_hit_i <= 1'b1;
    @(posedge sys_clk_i);
    addr_cycle_i <= 1'b0;
    lookup_store_i <= 1'b1;
    #1;
    chk(64'(bus_uc_o), 64'h2);
    chk({inval_load_o, inval_store_o}, 2'b10);
    @(posedge sys_clk_i);
    lookup_hit_i <= 1'b0;
    #1;
    chk({inval_load_o, inval_store_o}, 2'b01);
    end_of_test();
  end
endmodule // tb_tlb_management_registers
